// ---- logic/cmd_pkg.sv ----
// Shared constants and types for the core register file and memory decoder
package cmd_pkg;
    localparam logic [15:0] IO_DIRECT_END = 16'h003F;
    localparam logic [15:0] IO_SPACE_END = 16'h0FFF;
    localparam logic [15:0] EEP_BASE = 16'h1000;
    localparam logic [15:0] EEP_END = 16'h1FFF;
    localparam logic [15:0] SRAM_BASE = 16'h2000;
    localparam logic [15:0] SRAM_SIZE = 16'h1000;
    localparam logic [14:0] APPTABLE_BASE = 15'h3000;
    localparam logic [14:0] BOOT_BASE = 15'h4000;
    localparam logic [4:0] PTR_BASE = 5'h1A;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int LOCK_WR = 0;
    localparam int LOCK_RD = 1;

    typedef enum logic [3:0] {
        CMD_OP_ADD = 4'h0,
        CMD_OP_ADC = 4'h1,
        CMD_OP_SUB = 4'h2,
        CMD_OP_SBC = 4'h3,
        CMD_OP_AND = 4'h4,
        CMD_OP_OR = 4'h5,
        CMD_OP_EOR = 4'h6,
        CMD_OP_MOV = 4'h7,
        CMD_OP_INC = 4'h8,
        CMD_OP_DEC = 4'h9,
        CMD_OP_COM = 4'hA,
        CMD_OP_NEG = 4'hB,
        CMD_OP_LSR = 4'hC
    } cmd_op_type;

    typedef enum logic [1:0] {
        CMD_SEC_APP = 2'b00,
        CMD_SEC_TABLE = 2'b01,
        CMD_SEC_BOOT = 2'b10
    } cmd_sec_type;
endpackage

// ---- logic/cmd_rf_if.sv ----
// Port bundle between the decoder core and its working register file
`timescale 1ns/1ns
interface cmd_rf_if;
    logic [4:0] addr_a;
    logic [4:0] addr_b;
    logic [7:0] rdata_a;
    logic [7:0] rdata_b;
    logic we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [1:0] ptr_sel;
    logic [15:0] ptr_rdata;
    logic ptr_we;
    logic [15:0] ptr_wdata;
    modport core (output addr_a, addr_b, we, waddr, wdata, ptr_sel, ptr_we, ptr_wdata,
                  input rdata_a, rdata_b, ptr_rdata);
    modport regs (input addr_a, addr_b, we, waddr, wdata, ptr_sel, ptr_we, ptr_wdata,
                  output rdata_a, rdata_b, ptr_rdata);
endinterface

// ---- logic/cmd_regfile.sv ----
// Thirty-two byte working registers with registered read ports and pointer pairs
`timescale 1ns/1ns
module cmd_regfile
    import cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    cmd_rf_if.regs rf
);
    logic [7:0] mem [0:31];
    logic [4:0] ptr_lo;

    assign ptr_lo = 5'(PTR_BASE + {2'b00, rf.ptr_sel, 1'b0});

    always_ff @(posedge clk) begin
        if (rf.we) begin
            mem[rf.waddr] <= rf.wdata;
        end
        if (rf.ptr_we) begin
            mem[ptr_lo] <= rf.ptr_wdata[7:0];
            mem[5'(ptr_lo + 5'h01)] <= rf.ptr_wdata[15:8];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rf.rdata_a <= BYTE_ZERO;
            rf.rdata_b <= BYTE_ZERO;
            rf.ptr_rdata <= {BYTE_ZERO, BYTE_ZERO};
        end else begin
            rf.rdata_a <= mem[rf.addr_a];
            rf.rdata_b <= mem[rf.addr_b];
            rf.ptr_rdata <= {mem[5'(ptr_lo + 5'h01)], mem[ptr_lo]};
        end
    end
endmodule

// ---- logic/cmd_core.sv ----
// Working registers, flag-setting arithmetic unit and memory space decoding
`timescale 1ns/1ns
module cmd_core
    import cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic alu_valid,
    input wire logic [3:0] alu_op,
    input wire logic [4:0] alu_dst,
    input wire logic [4:0] alu_src,
    input wire logic alu_use_imm,
    input wire logic [7:0] alu_imm,
    output logic alu_done,
    output logic [7:0] alu_result,
    output logic [7:0] status_flags,
    input wire logic [1:0] ptr_sel,
    input wire logic ptr_we,
    input wire logic [15:0] ptr_wdata,
    output logic [15:0] ptr_value,
    input wire logic dat_req,
    input wire logic dat_we,
    input wire logic dat_io_direct,
    input wire logic [15:0] dat_addr,
    input wire logic [7:0] dat_wdata,
    input wire logic eep_mapped,
    input wire logic xram_present,
    output logic io_sel,
    output logic eep_sel,
    output logic sram_sel,
    output logic xram_sel,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic dat_refused,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] eep_rdata,
    input wire logic [7:0] sram_rdata,
    input wire logic [7:0] xram_rdata,
    output logic dat_rvalid,
    output logic [7:0] dat_rdata,
    input wire logic fetch_req,
    input wire logic [14:0] fetch_addr,
    output logic pm_fetch,
    input wire logic pm_read_req,
    input wire logic [14:0] pm_read_addr,
    output logic pm_read,
    output logic [14:0] pm_addr,
    input wire logic spm_req,
    input wire logic [14:0] spm_pc,
    input wire logic [14:0] spm_addr,
    output logic spm_go,
    output logic pm_denied,
    input wire logic [14:0] cur_pc,
    input wire logic [1:0] lock_app,
    input wire logic [1:0] lock_table,
    input wire logic [1:0] lock_boot
);
    cmd_rf_if rf();

    cmd_regfile u_regs (
        .clk(clk),
        .rst(rst),
        .rf(rf)
    );

    // Add or subtract with carry, returning {H, V, C, result}
    function automatic logic [10:0] addsub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [8:0] sum;
        logic [4:0] low;
        logic [7:0] bb;
        bb = sub ? ~b : b;
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin ^ sub};
        low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
        addsub = {low[4] ^ sub, (a[7] == bb[7]) && (sum[7] != a[7]), sum[8] ^ sub, sum[7:0]};
    endfunction

    function automatic cmd_sec_type section_of(input logic [14:0] addr);
        if (addr >= BOOT_BASE) begin
            section_of = CMD_SEC_BOOT;
        end else if (addr >= APPTABLE_BASE) begin
            section_of = CMD_SEC_TABLE;
        end else begin
            section_of = CMD_SEC_APP;
        end
    endfunction

    function automatic logic locked(input cmd_sec_type sec, input logic [1:0] la,
                                    input logic [1:0] lt, input logic [1:0] lb, input int k);
        case (sec)
            CMD_SEC_BOOT: locked = lb[k];
            CMD_SEC_TABLE: locked = lt[k];
            default: locked = la[k];
        endcase
    endfunction

    // Arithmetic pipeline: operands come from registered reads in stage 1
    logic s1_valid;
    cmd_op_type s1_op;
    logic [4:0] s1_dst;
    logic [4:0] s1_src;
    logic s1_use_imm;
    logic [7:0] s1_imm;
    logic last_we;
    logic [4:0] last_waddr;
    logic [7:0] last_wdata;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic [7:0] next_result;
    logic [7:0] next_flags;
    logic next_write;
    logic [10:0] as;

    assign rf.addr_a = alu_dst;
    assign rf.addr_b = alu_src;
    assign rf.ptr_sel = ptr_sel;
    assign rf.ptr_we = ptr_we;
    assign rf.ptr_wdata = ptr_wdata;
    assign rf.we = s1_valid && next_write;
    assign rf.waddr = s1_dst;
    assign rf.wdata = next_result;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_valid <= 1'b0;
            s1_op <= CMD_OP_ADD;
            s1_dst <= 5'h00;
            s1_src <= 5'h00;
            s1_use_imm <= 1'b0;
            s1_imm <= BYTE_ZERO;
            last_we <= 1'b0;
            last_waddr <= 5'h00;
            last_wdata <= BYTE_ZERO;
        end else begin
            s1_valid <= alu_valid;
            s1_op <= cmd_op_type'(alu_op);
            s1_dst <= alu_dst;
            s1_src <= alu_src;
            s1_use_imm <= alu_use_imm;
            s1_imm <= alu_imm;
            last_we <= rf.we;
            last_waddr <= s1_dst;
            last_wdata <= next_result;
        end
    end

    // Forward the value written in the same edge the operands were read
    always_comb begin
        op_a = (last_we && last_waddr == s1_dst) ? last_wdata : rf.rdata_a;
        op_b = (last_we && last_waddr == s1_src) ? last_wdata : rf.rdata_b;
        if (s1_use_imm) begin
            op_b = s1_imm;
        end
    end

    always_comb begin
        next_flags = status_flags;
        next_write = 1'b1;
        as = 11'h000;
        next_result = op_a;
        case (s1_op)
            CMD_OP_ADD, CMD_OP_ADC: as = addsub(op_a, op_b, s1_op == CMD_OP_ADC &&
                                                status_flags[FLAG_C], 1'b0);
            CMD_OP_SUB, CMD_OP_SBC: as = addsub(op_a, op_b, s1_op == CMD_OP_SBC &&
                                                status_flags[FLAG_C], 1'b1);
            CMD_OP_NEG: as = addsub(BYTE_ZERO, op_a, 1'b0, 1'b1);
            default: as = 11'h000;
        endcase
        case (s1_op)
            CMD_OP_ADD, CMD_OP_ADC, CMD_OP_SUB, CMD_OP_SBC, CMD_OP_NEG: begin
                next_result = as[7:0];
                next_flags[FLAG_C] = as[8];
                next_flags[FLAG_V] = as[9];
                next_flags[FLAG_H] = as[10];
            end
            CMD_OP_AND: next_result = op_a & op_b;
            CMD_OP_OR: next_result = op_a | op_b;
            CMD_OP_EOR: next_result = op_a ^ op_b;
            CMD_OP_MOV: next_result = op_b;
            CMD_OP_INC: next_result = 8'(op_a + 8'h01);
            CMD_OP_DEC: next_result = 8'(op_a - 8'h01);
            CMD_OP_COM: begin
                next_result = ~op_a;
                next_flags[FLAG_C] = 1'b1;
            end
            CMD_OP_LSR: begin
                next_result = {1'b0, op_a[7:1]};
                next_flags[FLAG_C] = op_a[0];
            end
            default: next_write = 1'b0;
        endcase
        case (s1_op)
            CMD_OP_AND, CMD_OP_OR, CMD_OP_EOR, CMD_OP_COM: next_flags[FLAG_V] = 1'b0;
            CMD_OP_INC: next_flags[FLAG_V] = (next_result == 8'h80);
            CMD_OP_DEC: next_flags[FLAG_V] = (next_result == 8'h7F);
            CMD_OP_LSR: next_flags[FLAG_V] = op_a[0];
            default: next_flags[FLAG_V] = next_flags[FLAG_V];
        endcase
        if (s1_op != CMD_OP_MOV) begin
            next_flags[FLAG_Z] = (next_result == BYTE_ZERO);
            next_flags[FLAG_N] = next_result[7];
            next_flags[FLAG_S] = next_result[7] ^ next_flags[FLAG_V];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alu_done <= 1'b0;
            alu_result <= BYTE_ZERO;
            status_flags <= STATUS_RESET;
            ptr_value <= {BYTE_ZERO, BYTE_ZERO};
        end else begin
            alu_done <= s1_valid && next_write;
            ptr_value <= rf.ptr_rdata;
            if (s1_valid && next_write) begin
                alu_result <= next_result;
                status_flags <= next_flags;
            end
        end
    end

    // Data space decoding
    logic [15:0] eff_addr;
    logic hit_io;
    logic hit_eep;
    logic hit_sram;
    logic hit_xram;
    logic bad_io;
    logic rd_pend;

    always_comb begin
        eff_addr = dat_io_direct ? {10'h000, dat_addr[5:0]} : dat_addr;
        bad_io = dat_io_direct && dat_addr > IO_DIRECT_END;
        hit_io = eff_addr <= IO_SPACE_END;
        hit_eep = eff_addr >= EEP_BASE && eff_addr <= EEP_END && eep_mapped;
        hit_sram = eff_addr >= SRAM_BASE && eff_addr < 16'(SRAM_BASE + SRAM_SIZE);
        hit_xram = eff_addr >= 16'(SRAM_BASE + SRAM_SIZE) && xram_present;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_sel <= 1'b0;
            eep_sel <= 1'b0;
            sram_sel <= 1'b0;
            xram_sel <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= BYTE_ZERO;
            dat_refused <= 1'b0;
            rd_pend <= 1'b0;
        end else begin
            io_sel <= dat_req && !bad_io && hit_io;
            eep_sel <= dat_req && !bad_io && hit_eep;
            sram_sel <= dat_req && !bad_io && hit_sram;
            xram_sel <= dat_req && !bad_io && hit_xram;
            mem_we <= dat_req && dat_we && !bad_io;
            dat_refused <= dat_req && bad_io;
            rd_pend <= dat_req && !dat_we;
            if (dat_req) begin
                mem_addr <= eff_addr;
                mem_wdata <= dat_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_rvalid <= 1'b0;
            dat_rdata <= BYTE_ZERO;
        end else begin
            dat_rvalid <= rd_pend;
            if (rd_pend) begin
                dat_rdata <= io_sel ? io_rdata : eep_sel ? eep_rdata : sram_sel ? sram_rdata :
                             xram_sel ? xram_rdata : BYTE_ZERO;
            end
        end
    end

    // Program space: fetch, table read and self-programming checks
    cmd_sec_type rd_sec;
    cmd_sec_type spm_sec;
    logic rd_ok;
    logic spm_ok;

    always_comb begin
        rd_sec = section_of(pm_read_addr);
        spm_sec = section_of(spm_addr);
        rd_ok = !locked(rd_sec, lock_app, lock_table, lock_boot, LOCK_RD) ||
                rd_sec == section_of(cur_pc);
        spm_ok = section_of(spm_pc) == CMD_SEC_BOOT && spm_sec != CMD_SEC_BOOT &&
                 !locked(spm_sec, lock_app, lock_table, lock_boot, LOCK_WR);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pm_fetch <= 1'b0;
            pm_read <= 1'b0;
            pm_addr <= 15'h0000;
            spm_go <= 1'b0;
            pm_denied <= 1'b0;
        end else begin
            pm_fetch <= fetch_req;
            pm_read <= !fetch_req && pm_read_req && rd_ok;
            spm_go <= !fetch_req && !pm_read_req && spm_req && spm_ok;
            pm_denied <= (!fetch_req && pm_read_req && !rd_ok) ||
                         (!fetch_req && !pm_read_req && spm_req && !spm_ok);
            if (fetch_req) begin
                pm_addr <= fetch_addr;
            end else if (pm_read_req) begin
                pm_addr <= pm_read_addr;
            end else if (spm_req) begin
                pm_addr <= spm_addr;
            end
        end
    end
endmodule

// ---- tb/cmd_mem_model.sv ----
// Memory targets answering the decoder selects
`timescale 1ns/1ns
module cmd_mem_model (
    input wire logic clk,
    input wire logic io_sel,
    input wire logic eep_sel,
    input wire logic sram_sel,
    input wire logic xram_sel,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] io_rdata,
    output logic [7:0] eep_rdata,
    output logic [7:0] sram_rdata,
    output logic [7:0] xram_rdata
);
    logic [7:0] sram [0:255];
    logic [7:0] noise = 8'h00;
    // Unselected targets show a moving pattern, never a stale byte
    always_ff @(posedge clk) begin
        noise <= noise + 8'h3B;
        if (sram_sel && mem_we) begin
            sram[mem_addr[7:0]] <= mem_wdata;
        end
    end
    assign io_rdata = io_sel ? mem_addr[7:0] : noise;
    assign eep_rdata = eep_sel ? ~mem_addr[7:0] : noise;
    assign sram_rdata = sram_sel ? sram[mem_addr[7:0]] : noise;
    assign xram_rdata = xram_sel ? (mem_addr[7:0] ^ 8'h5A) : noise;
endmodule

// ---- tb/cmd_core_properties.sv ----
// Port timing checks for the core decoder
`timescale 1ns/1ns
module cmd_core_properties
    import cmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic alu_valid,
    input wire logic [3:0] alu_op,
    input wire logic alu_done,
    input wire logic [7:0] status_flags,
    input wire logic dat_req,
    input wire logic dat_we,
    input wire logic dat_io_direct,
    input wire logic [15:0] dat_addr,
    input wire logic eep_mapped,
    input wire logic xram_present,
    input wire logic io_sel,
    input wire logic eep_sel,
    input wire logic sram_sel,
    input wire logic xram_sel,
    input wire logic [15:0] mem_addr,
    input wire logic dat_refused,
    input wire logic dat_rvalid,
    input wire logic fetch_req,
    input wire logic pm_read_req,
    input wire logic spm_req,
    input wire logic [14:0] spm_pc,
    input wire logic pm_fetch,
    input wire logic pm_read,
    input wire logic spm_go,
    input wire logic pm_denied
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_dreq; dat_req && !dat_io_direct; endsequence
    sequence s_spm; spm_req && !fetch_req && !pm_read_req; endsequence
    property p_alu_done; alu_valid && alu_op <= 4'hC |-> ##2 alu_done; endproperty
    a_alu_done: assert property (p_alu_done) else $error("alu done late");
    property p_alu_nop; alu_valid && alu_op > 4'hC |-> ##2 !alu_done; endproperty
    a_alu_nop: assert property (p_alu_nop) else $error("unused op completed");
    property p_mov; alu_valid && alu_op == CMD_OP_MOV |-> ##2 $stable(status_flags); endproperty
    a_mov: assert property (p_mov) else $error("move changed flags");
    property p_io; s_dreq and dat_addr <= IO_SPACE_END |-> ##1 io_sel; endproperty
    a_io: assert property (p_io) else $error("io select missing");
    property p_refuse;
        dat_req && dat_io_direct && dat_addr > IO_DIRECT_END |-> ##1 dat_refused && !io_sel;
    endproperty
    a_refuse: assert property (p_refuse) else $error("direct access not refused");
    property p_eep;
        s_dreq and dat_addr inside {[EEP_BASE:EEP_END]} |-> ##1 eep_sel == $past(eep_mapped);
    endproperty
    a_eep: assert property (p_eep) else $error("eeprom window select wrong");
    property p_sram;
        s_dreq and dat_addr inside {[SRAM_BASE:16'h2FFF]} |->
            ##1 sram_sel && mem_addr == $past(dat_addr);
    endproperty
    a_sram: assert property (p_sram) else $error("sram select wrong");
    property p_xram;
        s_dreq and dat_addr >= 16'h3000 |-> ##1 xram_sel == $past(xram_present);
    endproperty
    a_xram: assert property (p_xram) else $error("external select wrong");
    property p_rd; s_dreq and !dat_we |-> ##2 dat_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_fetch; fetch_req |-> ##1 pm_fetch && !pm_read && !spm_go; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not served");
    property p_spm; s_spm and spm_pc < BOOT_BASE |-> ##1 pm_denied && !spm_go; endproperty
    a_spm: assert property (p_spm) else $error("store outside boot accepted");
endmodule

// ---- tb/cmd_core_test.sv ----
// Directed scenarios for the core decoder
`timescale 1ns/1ns
bind cmd_core cmd_core_properties u_props (.*);
module cmd_core_test import cmd_pkg::*; ;
    logic clk = 0;
    logic rst = 1;
    logic alu_valid, alu_use_imm, ptr_we, dat_req, dat_we, dat_io_direct, eep_mapped;
    logic xram_present, fetch_req, pm_read_req, spm_req, alu_done, dat_refused, io_sel;
    logic eep_sel, sram_sel, xram_sel, mem_we, dat_rvalid, pm_fetch, pm_read, spm_go, pm_denied;
    logic [3:0] alu_op;
    logic [4:0] alu_dst, alu_src;
    logic [7:0] alu_imm, alu_result, status_flags, dat_wdata, io_rdata, eep_rdata;
    logic [7:0] sram_rdata, xram_rdata, mem_wdata, dat_rdata;
    logic [1:0] ptr_sel, lock_app, lock_table, lock_boot;
    logic [15:0] ptr_wdata, ptr_value, dat_addr, mem_addr;
    logic [14:0] fetch_addr, pm_read_addr, pm_addr, spm_pc, spm_addr, cur_pc;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    cmd_core u_dut (.*);
    cmd_mem_model u_mem (.*);
    always #2 clk = ~clk;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tally_and_finish;
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    task automatic alu_go(input logic [3:0] op, input logic [4:0] d, s, input logic u,
                          input logic [7:0] imm);
        {alu_valid, alu_op, alu_dst, alu_src, alu_use_imm, alu_imm} = {1'b1, op, d, s, u, imm};
        @(negedge clk);
    endtask
    // Done pulse, or its absence for an unused op, is sampled at the second edge after the last request
    task automatic alu_end(input logic [7:0] res, flags, input logic done);
        alu_valid = 0;
        @(negedge clk);
        chk("alu done", alu_done, done);
        chk("alu result", alu_result, res);
        chk("alu flags", status_flags, flags);
    endtask
    task t_alu;
        alu_go(CMD_OP_MOV, 5'h01, 5'h00, 1, 8'h05);
        alu_go(CMD_OP_ADD, 5'h01, 5'h00, 1, 8'hFB);
        alu_end(8'h00, 8'h23, 1);
        alu_go(CMD_OP_MOV, 5'h02, 5'h00, 1, 8'h7F);
        alu_go(CMD_OP_INC, 5'h02, 5'h00, 0, 8'h00);
        alu_end(8'h80, 8'h2D, 1);
        alu_go(4'hD, 5'h02, 5'h00, 0, 8'h00);
        alu_end(8'h80, 8'h2D, 0);
        alu_go(CMD_OP_ADD, 5'h02, 5'h01, 0, 8'h00);
        alu_end(8'h80, 8'h14, 1);
        alu_go(CMD_OP_SUB, 5'h02, 5'h00, 1, 8'h81);
        alu_end(8'hFF, 8'h35, 1);
    endtask
    task t_ptr;
        {ptr_sel, ptr_wdata, ptr_we} = {2'h1, 16'h1234, 1'b1};
        @(negedge clk);
        ptr_we = 0;
        alu_go(CMD_OP_AND, 5'h1C, 5'h00, 1, 8'hFF);
        alu_end(8'h34, 8'h21, 1);
        alu_go(CMD_OP_MOV, 5'h1F, 5'h00, 1, 8'hAB);
        alu_go(CMD_OP_MOV, 5'h1E, 5'h00, 1, 8'hCD);
        alu_end(8'hCD, 8'h21, 1);
        ptr_sel = 2'h2;
        repeat (2) @(negedge clk);
        chk("pointer pair", ptr_value, 16'hABCD);
    endtask
    task automatic dat_wr(input logic [15:0] a, input logic [7:0] d);
        {dat_addr, dat_wdata, dat_we, dat_io_direct, dat_req} = {a, d, 3'b101};
        @(negedge clk);
        {dat_req, dat_we} = 2'b00;
        chk("write strobes", {sram_sel, mem_we, mem_wdata}, {2'b11, d});
        @(negedge clk);
    endtask
    task automatic dat_chk(input logic [15:0] a, input logic [2:0] mode, input logic [4:0] sel,
                           input logic [7:0] d);
        {dat_addr, dat_io_direct, eep_mapped, xram_present, dat_req} = {a, mode, 1'b1};
        @(negedge clk);
        dat_req = 0;
        chk("selects", {io_sel, eep_sel, sram_sel, xram_sel, dat_refused}, sel);
        @(negedge clk);
        chk("read data", {dat_rvalid, dat_rdata}, {1'b1, d});
    endtask
    task t_data;
        dat_wr(16'h2000, 8'h11);
        dat_wr(16'h2FFF, 8'h22);
        dat_wr(16'h2010, 8'h3C);
        dat_chk(16'h0010, 3'b100, 5'b10000, 8'h10);
        dat_chk(16'h0010, 3'b000, 5'b10000, 8'h10);
        dat_chk(16'h0045, 3'b100, 5'b00001, 8'h00);
        dat_chk(16'h0045, 3'b000, 5'b10000, 8'h45);
        dat_chk(16'h0FFF, 3'b000, 5'b10000, 8'hFF);
        dat_chk(16'h1000, 3'b010, 5'b01000, 8'hFF);
        dat_chk(16'h1FFF, 3'b000, 5'b00000, 8'h00);
        dat_chk(16'h2000, 3'b000, 5'b00100, 8'h11);
        dat_chk(16'h2FFF, 3'b000, 5'b00100, 8'h22);
        dat_chk(16'h2010, 3'b000, 5'b00100, 8'h3C);
        dat_chk(16'h3000, 3'b001, 5'b00010, 8'h5A);
        dat_chk(16'h3000, 3'b000, 5'b00000, 8'h00);
    endtask
    task automatic pm_chk(input logic [2:0] req, input logic [14:0] a, pc, input logic [5:0] lk,
                          input logic [3:0] exp);
        {fetch_req, pm_read_req, spm_req} = req;
        {fetch_addr, pm_read_addr, spm_addr, spm_pc, cur_pc} = {a, a, a, pc, pc};
        {lock_app, lock_table, lock_boot} = lk;
        @(negedge clk);
        {fetch_req, pm_read_req, spm_req} = 3'b000;
        chk("program strobes", {pm_fetch, pm_read, spm_go, pm_denied}, exp);
        if (exp[3:1] != 3'b000) begin
            chk("program address", pm_addr, a);
        end
        @(negedge clk);
    endtask
    task t_prog;
        pm_chk(3'b101, 15'h0100, 15'h4000, 6'h00, 4'b1000);
        pm_chk(3'b001, 15'h0100, 15'h4000, 6'h00, 4'b0010);
        pm_chk(3'b001, 15'h0100, 15'h1000, 6'h00, 4'b0001);
        pm_chk(3'b001, 15'h4100, 15'h4000, 6'h00, 4'b0001);
        pm_chk(3'b001, 15'h0100, 15'h4000, 6'h10, 4'b0001);
        pm_chk(3'b001, 15'h3000, 15'h4000, 6'h04, 4'b0001);
        pm_chk(3'b001, 15'h0100, 15'h4000, 6'h04, 4'b0010);
        pm_chk(3'b010, 15'h3000, 15'h0100, 6'h08, 4'b0001);
        pm_chk(3'b010, 15'h3000, 15'h3100, 6'h08, 4'b0100);
        pm_chk(3'b010, 15'h4000, 15'h0100, 6'h02, 4'b0001);
        pm_chk(3'b010, 15'h0200, 15'h0100, 6'h20, 4'b0100);
        pm_chk(3'b110, 15'h0300, 15'h0100, 6'h00, 4'b1000);
    endtask
    initial begin
        {alu_valid, alu_op, alu_dst, alu_src, alu_use_imm, alu_imm, ptr_sel, ptr_we} = '0;
        {ptr_wdata, dat_req, dat_we, dat_io_direct, dat_addr, dat_wdata, eep_mapped} = '0;
        {xram_present, fetch_req, fetch_addr, pm_read_req, pm_read_addr, spm_req} = '0;
        {spm_pc, spm_addr, cur_pc, lock_app, lock_table, lock_boot} = '0;
        repeat (16) @(negedge clk);
        rst = 0;
        @(negedge clk);
        t_alu;
        t_ptr;
        t_data;
        t_prog;
        tally_and_finish;
    end
endmodule
